/* irq_level_priority_encoder.sv */
// Board interrupt prioritiser: requests in, encoded level and NMI out.
// Assumes all request inputs synchronous to clk_sys (rst acts asynchronously); slot lines pulled up.
`timescale 1ns/10ps
`include "irq_prio_map.svh"

// Function
// RULE1: Present only the highest pending request as inverted 4-bit level.
// RULE2: Abort or emulator request goes out as NMI, no level code; the code has only the abort input abort_req_n.
// RULE3: Slot line 8 is level 15 code 0000; line 7 level 14.
// RULE4: Card line 2 is level 13; multi-I/O request is level 12.
// RULE5: Slot line 6 is level 11; slot line 5 is level 10.
// RULE6: Card line 1 is level 9, code 0110.
// RULE7: Slot line 4 is level 7; slot line 3 is level 6.
// RULE8: Slot line 2 is level 4; slot line 1 is level 2.
// RULE9: Card line 0 is level 1, only when nothing higher pends.
// RULE10: Codes 0111, 1010 and 1100 are never driven.
// RULE11: Slot requests are active low, idle high by pull-ups.
// RULE12: Idle code 1111; outputs change on the system clock.
module irq_level_priority_encoder
  import irq_prio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slot_req1_n,
  input wire logic slot_req2_n,
  input wire logic slot_req3_n,
  input wire logic slot_req4_n,
  input wire logic slot_req5_n,
  input wire logic slot_req6_n,
  input wire logic slot_req7_n,
  input wire logic slot_req8_n,
  input wire logic card_ctrl_req0_n,
  input wire logic card_ctrl_req1_n,
  input wire logic card_ctrl_req2_n,
  input wire logic multi_io_request,
  input wire logic abort_req_n,
  output level_code_t cpu_int_level_code,
  output logic cpu_nmi_n,
  output logic int_pending
);

  // ----------------------------------------------------------------
  // Request gathering
  // ----------------------------------------------------------------
  req_vec_s req_now;
  level_code_t enc_code;
  enc_state_e state;
  enc_state_e next_state;
  level_code_t next_code;
  logic next_nmi_n;
  logic next_pending;

  always_comb
  begin
    // Active-low lines inverted; multi-I/O is active high
    req_now.slot8 = ~slot_req8_n; // see RULE11
    req_now.slot7 = ~slot_req7_n; // see RULE11
    req_now.slot6 = ~slot_req6_n; // see RULE11
    req_now.slot5 = ~slot_req5_n; // see RULE11
    req_now.slot4 = ~slot_req4_n; // see RULE11
    req_now.slot3 = ~slot_req3_n; // see RULE11
    req_now.slot2 = ~slot_req2_n; // see RULE11
    req_now.slot1 = ~slot_req1_n; // see RULE11
    req_now.card2 = ~card_ctrl_req2_n;
    req_now.card1 = ~card_ctrl_req1_n;
    req_now.card0 = ~card_ctrl_req0_n;
    req_now.multi_io = multi_io_request;
    // No source on the spare position
    req_now.spare = 1'b0;
  end

  irq_prio_encode u_encode (
    .req(req_now),
    .code(enc_code)
  );

  // ----------------------------------------------------------------
  // Output state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_code = enc_code; // see RULE1
    next_nmi_n = abort_req_n; // see RULE2
    next_pending = (enc_code != `CODE_NONE);
    unique case (state)
      ST_IDLE:
        next_state = next_pending ? ST_PEND : ST_IDLE;
      ST_PEND:
        next_state = next_pending ? ST_PEND : ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cpu_int_level_code <= `CODE_NONE; // see RULE12
      cpu_nmi_n <= `NMI_IDLE;
      int_pending <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cpu_int_level_code <= next_code; // see RULE12
      cpu_nmi_n <= next_nmi_n;
      int_pending <= next_pending;
    end
  end

  // ----------------------------------------------------------------
  // Ranking table for the checks
  // ----------------------------------------------------------------
  // Kept as a table, apart from the encoder's if-chain, so a slip
  // in either one shows up as a disagreement
  function automatic level_code_t rank_code(input int pos);
    level_code_t code;
    case (pos)
      12: code = `CODE_LVL15;
      11: code = `CODE_LVL14;
      10: code = `CODE_LVL13;
      9: code = `CODE_LVL12;
      8: code = `CODE_LVL11;
      7: code = `CODE_LVL10;
      6: code = `CODE_LVL9;
      5: code = `CODE_LVL7;
      4: code = `CODE_LVL6;
      3: code = `CODE_LVL4;
      2: code = `CODE_LVL2;
      1: code = `CODE_LVL1;
      default: code = `CODE_NONE;
    endcase
    return code;
  endfunction : rank_code

  // Lowest rank first, so the highest active source is left standing
  function automatic level_code_t table_code(input req_vec_s r);
    logic [12:0] bits;
    level_code_t code;
    bits = r;
    code = `CODE_NONE;
    for (int i = 1; i < 13; i++)
      if (bits[i])
        code = rank_code(i);
    return code;
  endfunction : table_code

  // True when no source ranked above the given position is active
  function automatic logic clear_above(input req_vec_s r, input int pos);
    logic [12:0] bits;
    bits = r;
    return (bits >> (pos + 1)) == 13'h0000;
  endfunction : clear_above

  level_code_t table_now;
  assign table_now = table_code(req_now);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_top_slot8: assert property ( // see RULE3
    !slot_req8_n |=> cpu_int_level_code == `CODE_LVL15)
    else $error("slot 8 did not give level 15");
  a_slot7_level: assert property ( // see RULE3
    slot_req8_n && !slot_req7_n |=> cpu_int_level_code == `CODE_LVL14)
    else $error("slot 7 did not give level 14");
  a_card2_multi: assert property ( // see RULE4
    slot_req8_n && slot_req7_n && !card_ctrl_req2_n
    |=> cpu_int_level_code == `CODE_LVL13)
    else $error("card 2 did not give level 13");
  a_multi_io_level: assert property ( // see RULE4
    (req_now[12:10] == 3'h0) && multi_io_request
    |=> cpu_int_level_code == `CODE_LVL12)
    else $error("multi I/O did not give level 12");
  a_slot6_level: assert property ( // see RULE5
    (req_now[12:9] == 4'h0) && !slot_req6_n
    |=> cpu_int_level_code == `CODE_LVL11)
    else $error("slot 6 did not give level 11");
  a_card1_level: assert property ( // see RULE6
    (req_now[12:7] == 6'h00) && !card_ctrl_req1_n
    |=> cpu_int_level_code == `CODE_LVL9)
    else $error("card 1 did not give level 9");
  a_slot4_level: assert property ( // see RULE7
    (req_now[12:6] == 7'h00) && !slot_req4_n
    |=> cpu_int_level_code == `CODE_LVL7)
    else $error("slot 4 did not give level 7");
  a_slot2_level: assert property ( // see RULE8
    (req_now[12:4] == 9'h000) && !slot_req2_n
    |=> cpu_int_level_code == `CODE_LVL4)
    else $error("slot 2 did not give level 4");
  a_card0_lowest: assert property ( // see RULE9
    clear_above(req_now, 1) ##1 cpu_int_level_code == `CODE_LVL1
    |-> $past(!card_ctrl_req0_n))
    else $error("level 1 without card 0 alone");
  a_no_unused_code: assert property ( // see RULE10
    cpu_int_level_code != `CODE_LVL8 && cpu_int_level_code != `CODE_LVL5
    && cpu_int_level_code != `CODE_LVL3)
    else $error("unassigned level code driven");
  a_idle_code: assert property ( // see RULE12
    req_now == `REQ_IDLE |=> cpu_int_level_code == `CODE_NONE
    && !int_pending)
    else $error("idle code not driven");
  a_nmi_bypass: assert property ( // see RULE2
    !abort_req_n && req_now == `REQ_IDLE
    |=> !cpu_nmi_n && cpu_int_level_code == `CODE_NONE)
    else $error("NMI entered level encoding");
  a_highest_wins: assert property ( // see RULE1
    !slot_req8_n && !card_ctrl_req0_n
    |=> cpu_int_level_code == `CODE_LVL15)
    else $error("lower request won over higher");

  // Remaining single levels
  a_slot5_level: assert property ( // see RULE5
    clear_above(req_now, 7) && !slot_req5_n
    |=> cpu_int_level_code == `CODE_LVL10)
    else $error("slot 5 did not give level 10");
  a_slot3_level: assert property ( // see RULE7
    clear_above(req_now, 4) && !slot_req3_n
    |=> cpu_int_level_code == `CODE_LVL6)
    else $error("slot 3 did not give level 6");
  a_slot1_level: assert property ( // see RULE8
    clear_above(req_now, 2) && !slot_req1_n
    |=> cpu_int_level_code == `CODE_LVL2)
    else $error("slot 1 did not give level 2");
  a_code_table: assert property ( // see RULE1
    1'b1 |=> cpu_int_level_code == $past(table_now))
    else $error("level code differs from ranking table");

  // Neighbours in the ranking, both active at once
  a_slot7_over_card2: assert property ( // see RULE1
    clear_above(req_now, 11) && !slot_req7_n && !card_ctrl_req2_n
    |=> cpu_int_level_code == `CODE_LVL14)
    else $error("card 2 won over slot 7");
  a_card2_over_multi: assert property ( // see RULE1
    clear_above(req_now, 10) && !card_ctrl_req2_n && multi_io_request
    |=> cpu_int_level_code == `CODE_LVL13)
    else $error("multi I/O won over card 2");
  a_multi_over_slot6: assert property ( // see RULE1
    clear_above(req_now, 9) && multi_io_request && !slot_req6_n
    |=> cpu_int_level_code == `CODE_LVL12)
    else $error("slot 6 won over multi I/O");
  a_slot6_over_slot5: assert property ( // see RULE1
    clear_above(req_now, 8) && !slot_req6_n && !slot_req5_n
    |=> cpu_int_level_code == `CODE_LVL11)
    else $error("slot 5 won over slot 6");
  a_slot5_over_card1: assert property ( // see RULE1
    clear_above(req_now, 7) && !slot_req5_n && !card_ctrl_req1_n
    |=> cpu_int_level_code == `CODE_LVL10)
    else $error("card 1 won over slot 5");
  a_card1_over_slot4: assert property ( // see RULE1
    clear_above(req_now, 6) && !card_ctrl_req1_n && !slot_req4_n
    |=> cpu_int_level_code == `CODE_LVL9)
    else $error("slot 4 won over card 1");
  a_slot4_over_slot3: assert property ( // see RULE1
    clear_above(req_now, 5) && !slot_req4_n && !slot_req3_n
    |=> cpu_int_level_code == `CODE_LVL7)
    else $error("slot 3 won over slot 4");
  a_slot3_over_slot2: assert property ( // see RULE1
    clear_above(req_now, 4) && !slot_req3_n && !slot_req2_n
    |=> cpu_int_level_code == `CODE_LVL6)
    else $error("slot 2 won over slot 3");
  a_slot2_over_slot1: assert property ( // see RULE1
    clear_above(req_now, 3) && !slot_req2_n && !slot_req1_n
    |=> cpu_int_level_code == `CODE_LVL4)
    else $error("slot 1 won over slot 2");
  a_slot1_over_card0: assert property ( // see RULE9
    clear_above(req_now, 2) && !slot_req1_n && !card_ctrl_req0_n
    |=> cpu_int_level_code == `CODE_LVL2)
    else $error("card 0 won over slot 1");
  a_card0_masked: assert property ( // see RULE9
    !card_ctrl_req0_n && !clear_above(req_now, 1)
    |=> cpu_int_level_code != `CODE_LVL1)
    else $error("card 0 shown while higher pending");

  // Abort path and status
  a_nmi_assert: assert property ( // see RULE2
    !abort_req_n |=> !cpu_nmi_n)
    else $error("abort request did not raise NMI");
  a_nmi_release: assert property ( // see RULE2
    abort_req_n |=> cpu_nmi_n)
    else $error("NMI held without abort request");
  a_nmi_no_level: assert property ( // see RULE2
    !abort_req_n && !card_ctrl_req0_n && clear_above(req_now, 1)
    |=> cpu_int_level_code == `CODE_LVL1)
    else $error("abort request changed the level code");
  a_nmi_not_code: assert property ( // see RULE2
    !abort_req_n && !clear_above(req_now, 0)
    |=> cpu_int_level_code != `CODE_NONE)
    else $error("abort request masked a pending level");
  a_pending_flag: assert property ( // see RULE12
    int_pending == (cpu_int_level_code != `CODE_NONE))
    else $error("pending flag disagrees with code");
  a_state_flag: assert property ( // see RULE12
    (state == ST_PEND) == int_pending)
    else $error("state disagrees with pending flag");
  a_state_legal: assert property ( // see RULE12
    state == ST_IDLE || state == ST_PEND)
    else $error("state left its legal codes");

  c_slot8: cover property (!slot_req8_n ##1 cpu_int_level_code == `CODE_LVL15);
  c_card0: cover property (cpu_int_level_code == `CODE_LVL1);
  c_nmi: cover property (!cpu_nmi_n);
  c_return_idle: cover property (int_pending ##1 !int_pending);
  c_nmi_level: cover property (!abort_req_n && !slot_req8_n ##1 !cpu_nmi_n);

endmodule : irq_level_priority_encoder

/* irq_prio_map.svh */
// Constants for the interrupt level priority encoder.
// Assumes inclusion by bare name from the package and modules.
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH

// ----------------------------------------------------------------
// Level codes on the processor pins (inverse of level number)
// ----------------------------------------------------------------
`define CODE_LVL15 4'h0
`define CODE_LVL14 4'h1
`define CODE_LVL13 4'h2
`define CODE_LVL12 4'h3
`define CODE_LVL11 4'h4
`define CODE_LVL10 4'h5
`define CODE_LVL9 4'h6
`define CODE_LVL8 4'h7
`define CODE_LVL7 4'h8
`define CODE_LVL6 4'h9
`define CODE_LVL5 4'hA
`define CODE_LVL4 4'hB
`define CODE_LVL3 4'hC
`define CODE_LVL2 4'hD
`define CODE_LVL1 4'hE
`define CODE_NONE 4'hF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define REQ_IDLE 13'h0000
`define NMI_IDLE 1'h1

`endif

/* irq_prio_pkg.sv */
// Types for the interrupt level priority encoder.
// Assumes the map header is on the include path.
`include "irq_prio_map.svh"

package irq_prio_pkg;

  // ----------------------------------------------------------------
  // Active-high request vector, one bit per source
  // ----------------------------------------------------------------
  typedef struct packed {
    logic slot8;
    logic slot7;
    logic card2;
    logic multi_io;
    logic slot6;
    logic slot5;
    logic card1;
    logic slot4;
    logic slot3;
    logic slot2;
    logic slot1;
    logic card0;
    logic spare;
  } req_vec_s;

  typedef logic [3:0] level_code_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PEND = 2'b10
  } enc_state_e;

endpackage : irq_prio_pkg

/* irq_prio_encode.sv */
// Combinational priority encoder from request vector to level code.
// Assumes active-high requests already gathered into a struct.
`timescale 1ns/10ps
`include "irq_prio_map.svh"

module irq_prio_encode
  import irq_prio_pkg::*;
(
  input wire req_vec_s req,
  output level_code_t code
);

  always_comb
  begin
    // Highest level first; levels 8, 5, 3 never chosen, see RULE10
    if (req.slot8)
      code = `CODE_LVL15; // see RULE3
    else if (req.slot7)
      code = `CODE_LVL14; // see RULE3
    else if (req.card2)
      code = `CODE_LVL13; // see RULE4
    else if (req.multi_io)
      code = `CODE_LVL12; // see RULE4
    else if (req.slot6)
      code = `CODE_LVL11; // see RULE5
    else if (req.slot5)
      code = `CODE_LVL10; // see RULE5
    else if (req.card1)
      code = `CODE_LVL9; // see RULE6
    else if (req.slot4)
      code = `CODE_LVL7; // see RULE7
    else if (req.slot3)
      code = `CODE_LVL6; // see RULE7
    else if (req.slot2)
      code = `CODE_LVL4; // see RULE8
    else if (req.slot1)
      code = `CODE_LVL2; // see RULE8
    else if (req.card0)
      code = `CODE_LVL1; // see RULE9
    else
      code = `CODE_NONE; // see RULE12
  end

endmodule : irq_prio_encode

/* cpu_irl_sink.sv */
// Processor side of the level pins: decodes the code to a level.
// Assumes the code and NMI come registered from the encoder.
`timescale 1ns/10ps

module cpu_irl_sink
  import irq_prio_pkg::*;
(
  input wire level_code_t code,
  input wire logic nmi_n,
  output logic [3:0] level,
  output logic bad_code,
  output logic nmi_seen
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign level = ~code;
  // No source exists at levels 8, 5 and 3
  assign bad_code = (code === 4'h7) || (code === 4'hA) ||
                    (code === 4'hC);
  assign nmi_seen = !nmi_n;
endmodule : cpu_irl_sink

/* tb.sv */
// Self-checking bench for the interrupt level priority encoder.
// Assumes one-cycle registered answer to every sampled input set.
`timescale 1ns/10ps

module tb
  import irq_prio_pkg::*;
;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] act = 12'h000;
  logic abort_n = 1'b1;
  level_code_t code;
  logic nmi_n, pend, bad, nmi_seen, armed, exp_nmi;
  logic [3:0] exp_code, lvl;
  logic [31:0] rv;
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'hA9828548;
  // Source order: slot8 slot7 card2 multi slot6 slot5 card1 slot4 ...
  int lv[12] = '{15, 14, 13, 12, 11, 10, 9, 7, 6, 4, 2, 1};

  always #12.5 clk_sys = ~clk_sys;

  irq_level_priority_encoder dut_u (
    .clk_sys(clk_sys), .rst(rst),
    .slot_req8_n(~act[0]), .slot_req7_n(~act[1]),
    .card_ctrl_req2_n(~act[2]), .multi_io_request(act[3]),
    .slot_req6_n(~act[4]), .slot_req5_n(~act[5]),
    .card_ctrl_req1_n(~act[6]), .slot_req4_n(~act[7]),
    .slot_req3_n(~act[8]), .slot_req2_n(~act[9]),
    .slot_req1_n(~act[10]), .card_ctrl_req0_n(~act[11]),
    .abort_req_n(abort_n), .cpu_int_level_code(code),
    .cpu_nmi_n(nmi_n), .int_pending(pend)
  );

  cpu_irl_sink cpu_u (
    .code(code), .nmi_n(nmi_n), .level(lvl), .bad_code(bad),
    .nmi_seen(nmi_seen)
  );

  // ----------------------------------------------------------------
  // Reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [3:0] model(input logic [11:0] a);
    int top;
    top = 0;
    for (int i = 0; i < 12; i++)
      if (a[i] && lv[i] > top)
        top = lv[i];
    return 4'(15 - top);
  endfunction : model

  task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task done(input string name);
    $display("test %s ended, checks %0d", name, checked);
  endtask : done

  task rst_chk;
    chk("reset code", 4'hF, code);
    chk("reset nmi", 4'h1, {3'h0, nmi_n});
    chk("reset pending", 4'h0, {3'h0, pend});
  endtask : rst_chk

  // Checks the previous set, then drives the next one
  task step(input logic [11:0] a, input logic ab);
    @(negedge clk_sys);
    if (armed)
    begin
      chk("level code", exp_code, code);
      chk("level number", ~exp_code, lvl);
      chk("nmi", {3'h0, ~exp_nmi}, {3'h0, nmi_seen});
      chk("pending", {3'h0, exp_code !== 4'hF}, {3'h0, pend});
      chk("unused code", 4'h0, {3'h0, bad});
    end
    act = a;
    abort_n = ab;
    exp_code = model(a);
    exp_nmi = ab;
    armed = 1'b1;
  endtask : step

  task conclude;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    armed = 1'b0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_chk();
    rst = 1'b0;
    done("reset");
    for (int i = 0; i < 12; i++)
    begin
      step(12'h001 << i, 1'b1);
      step(12'h000, 1'b1);
    end
    done("single source");
    // Ladder: each source against every lower one, changing each cycle
    for (int i = 0; i < 12; i++)
      step(12'hFFF << i, 1'b1);
    done("priority ladder");
    step(12'h001, 1'b0);
    step(12'h800, 1'b0);
    step(12'h000, 1'b1);
    done("nmi bypass");
    // Sparse requests so that low levels win often enough
    repeat (600)
    begin
      rv = $random(seed) & $random(seed) & $random(seed);
      step(rv[11:0], ~rv[31]);
    end
    done("random");
    step(12'h0FF, 1'b0);
    rst = 1'b1;
    #1;
    rst_chk();
    armed = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    step(12'h0FF, 1'b0);
    step(12'h000, 1'b1);
    step(12'h000, 1'b1);
    done("mid-run reset");
    conclude();
  end
endmodule : tb
